// ### hdl/uart_channel_setup_defines.vh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the design file, its checker and its bench
`ifndef UART_CHANNEL_SETUP_DEFINES_VH
`define UART_CHANNEL_SETUP_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_RX_CHANNEL_COMM_CONFIG 4'h0
`define OFS_RX_CHANNEL_DIVIDER_DATA 4'h1
`define OFS_SERIAL_OUTPUT_LEVEL 4'h2
`define OFS_SERIAL_OUTPUT_ENABLE 4'h3
`define OFS_PORT_A_LATCH 4'h4
`define OFS_PORT_A_DIRECTION 4'h5
`define OFS_PORT_B_LATCH 4'h6
`define OFS_PORT_B_DIRECTION 4'h7
`define OFS_RX_STATUS 4'h8
`define OFS_RX_DATA 4'h9
`define OFS_RX_START 4'hA

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RXE_BIT 14
`define PTC_HI 9
`define PTC_LO 8
`define DIR_BIT 7
`define SLC_HI 5
`define SLC_LO 4
`define DLS_HI 1
`define DLS_LO 0
`define DIV_HI 15
`define DIV_LO 9
`define TX_PIN_BIT 0
`define RX_PIN_BIT 7

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define DLS_9BIT 2'h1
`define DLS_7BIT 2'h2
`define DLS_8BIT 2'h3
`define PTC_NONE 2'h0
`define PTC_ZERO 2'h1
`define PTC_EVEN 2'h2
`define PTC_ODD 2'h3
`define SLC_NONE 2'h0
`define SLC_ONE 2'h1
`define SLC_TWO 2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_COMM_CONFIG 16'h4697
`define RST_DIVIDER_DATA 16'h9A00
`define RST_OUTPUT_LEVEL 16'h0F0F
`define RST_OUTPUT_ENABLE 16'h0001
`define RST_PORT_A_LATCH 8'h01
`define RST_PORT_A_DIRECTION 8'hFE
`define RST_PORT_B_LATCH 8'h00
`define RST_PORT_B_DIRECTION 8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RX_ENABLE_WAIT_CYCLES 3'h4

`endif

// ### hdl/uart_channel_setup.v
// Serial channel configuration registers, pin control and receive channel
// Assumes one clock, synchronous inputs and a single-cycle register port
`timescale 1ns/1ps
`include "uart_channel_setup_defines.vh"

// Summary of operation
// - Length code 01 gives 9 bits, 10 gives 7, 11 gives 8; 00 unused
// - Divider field bits 15..9 sets bit clock to clock over 2*(field+1)
// - Divider 1001101 gives operation clock over 156 for reception
// - Transmit level bit drives the line low or high; resets high
// - Output gate bit stops or enables serial output; resets enabled
// - Port latch bit drives stored level onto pin in output mode
// - Port direction bit 0 turns output buffer on, 1 turns it off
// - Transmit pin is output with latch high; receive pin is input
// - Parity field selects none, zero, even or odd; receive checks even and odd
// - Bit order 0 shifts MSB first, 1 shifts LSB first
// - Stop field selects none, one or two stop bits; 11 unused
module uart_channel_setup
(
    input wire core_clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] port_a_pin_in,
    input wire [7:0] port_b_pin_in,
    output reg [15:0] rdata_out,
    output reg [7:0] port_a_pin_out,
    output reg [7:0] port_a_pin_oe_n_out,
    output reg [7:0] port_b_pin_out,
    output reg [7:0] port_b_pin_oe_n_out
);

localparam ST_IDLE = 5'h01;
localparam ST_START = 5'h02;
localparam ST_DATA = 5'h04;
localparam ST_PARITY = 5'h08;
localparam ST_STOP = 5'h10;

reg [15:0] rx_channel_comm_config;
reg [15:0] rx_channel_divider_data;
reg [15:0] serial_output_level;
reg [15:0] serial_output_enable;
reg [7:0] port_a_latch;
reg [7:0] port_a_direction;
reg [7:0] port_b_latch;
reg [7:0] port_b_direction;
reg [4:0] state;
reg [7:0] div_cnt;
reg [3:0] bit_cnt;
reg [8:0] shift;
reg [8:0] rx_data;
reg rx_prev;
reg par_acc;
reg stop_cnt;
reg rx_active;
reg rx_done;
reg parity_error;
reg framing_error;
reg [2:0] enable_wait;
reg armed;

wire [1:0] char_length_sel;
wire [1:0] parity_sel;
wire [1:0] stop_bit_sel;
wire bit_order_select;
wire receive_enable_bit;
wire [6:0] div_field;
wire rx_line;
wire [7:0] half_period;
wire tick;
wire [7:0] next_port_a_pin;
wire [7:0] next_port_a_oe_n;
wire [7:0] next_port_b_pin;
wire [7:0] next_port_b_oe_n;
wire tx_drive;
wire channel_start_trigger;

// Number of data bits for a length code
function [3:0] data_bits;
    input [1:0] code;
    begin
        case (code)
            `DLS_9BIT: data_bits = 4'h9;
            `DLS_7BIT: data_bits = 4'h7;
            default: data_bits = 4'h8;
        endcase
    end
endfunction

assign char_length_sel = rx_channel_comm_config[`DLS_HI:`DLS_LO];
assign parity_sel = rx_channel_comm_config[`PTC_HI:`PTC_LO];
assign stop_bit_sel = rx_channel_comm_config[`SLC_HI:`SLC_LO];
assign bit_order_select = rx_channel_comm_config[`DIR_BIT];
assign receive_enable_bit = rx_channel_comm_config[`RXE_BIT];
assign div_field = rx_channel_divider_data[`DIV_HI:`DIV_LO];
assign rx_line = port_b_pin_in[`RX_PIN_BIT];
assign channel_start_trigger = wr_in && (addr_in == `OFS_RX_START) && wdata_in[0];

// ----------------------------------------------------------------
// Bit clock divider
// ----------------------------------------------------------------
// Full bit time is 2*(field+1) cycles; half period counts field+1
assign half_period = {1'b0, div_field} + 8'h01;
assign tick = (div_cnt == 8'h00);

// ----------------------------------------------------------------
// Pin control
// ----------------------------------------------------------------
// Transmit pin carries latch AND serial level while the gate is on
assign tx_drive = serial_output_enable[0] ? serial_output_level[0] : 1'b1;
assign next_port_a_pin = {port_a_latch[7:1], port_a_latch[`TX_PIN_BIT] & tx_drive};
assign next_port_a_oe_n = port_a_direction;
assign next_port_b_pin = port_b_latch;
assign next_port_b_oe_n = port_b_direction;

always @(posedge core_clk_in)
begin
    if (!rst_n_in)
    begin
        port_a_pin_out <= `RST_PORT_A_LATCH;
        port_a_pin_oe_n_out <= `RST_PORT_A_DIRECTION;
        port_b_pin_out <= `RST_PORT_B_LATCH;
        port_b_pin_oe_n_out <= `RST_PORT_B_DIRECTION;
    end
    else if (clk_en_in)
    begin
        port_a_pin_out <= next_port_a_pin;
        port_a_pin_oe_n_out <= next_port_a_oe_n;
        port_b_pin_out <= next_port_b_pin;
        port_b_pin_oe_n_out <= next_port_b_oe_n;
    end
end

// ----------------------------------------------------------------
// Register port
// ----------------------------------------------------------------
always @(posedge core_clk_in)
begin
    if (!rst_n_in)
    begin
        rx_channel_comm_config <= `RST_COMM_CONFIG;
        rx_channel_divider_data <= `RST_DIVIDER_DATA;
        serial_output_level <= `RST_OUTPUT_LEVEL;
        serial_output_enable <= `RST_OUTPUT_ENABLE;
        port_a_latch <= `RST_PORT_A_LATCH;
        port_a_direction <= `RST_PORT_A_DIRECTION;
        port_b_latch <= `RST_PORT_B_LATCH;
        port_b_direction <= `RST_PORT_B_DIRECTION;
        rdata_out <= 16'h0000;
    end
    else if (clk_en_in)
    begin
        if (wr_in)
        begin
            case (addr_in)
                `OFS_RX_CHANNEL_COMM_CONFIG: rx_channel_comm_config <= wdata_in;
                `OFS_RX_CHANNEL_DIVIDER_DATA: rx_channel_divider_data <= wdata_in;
                `OFS_SERIAL_OUTPUT_LEVEL: serial_output_level <= wdata_in;
                `OFS_SERIAL_OUTPUT_ENABLE: serial_output_enable <= wdata_in;
                `OFS_PORT_A_LATCH: port_a_latch <= wdata_in[7:0];
                `OFS_PORT_A_DIRECTION: port_a_direction <= wdata_in[7:0];
                `OFS_PORT_B_LATCH: port_b_latch <= wdata_in[7:0];
                `OFS_PORT_B_DIRECTION: port_b_direction <= wdata_in[7:0];
                default: ;
            endcase
        end
        if (rd_in)
        begin
            case (addr_in)
                `OFS_RX_CHANNEL_COMM_CONFIG: rdata_out <= rx_channel_comm_config;
                `OFS_RX_CHANNEL_DIVIDER_DATA: rdata_out <= rx_channel_divider_data;
                `OFS_SERIAL_OUTPUT_LEVEL: rdata_out <= serial_output_level;
                `OFS_SERIAL_OUTPUT_ENABLE: rdata_out <= serial_output_enable;
                `OFS_PORT_A_LATCH: rdata_out <= {8'h00, port_a_latch};
                `OFS_PORT_A_DIRECTION: rdata_out <= {8'h00, port_a_direction};
                `OFS_PORT_B_LATCH: rdata_out <= {8'h00, port_b_latch};
                `OFS_PORT_B_DIRECTION: rdata_out <= {8'h00, port_b_direction};
                `OFS_RX_STATUS: rdata_out <= {11'h000, (enable_wait == 3'h0), rx_active,
                                              framing_error, parity_error, rx_done};
                `OFS_RX_DATA: rdata_out <= {7'h00, rx_data};
                default: rdata_out <= 16'h0000;
            endcase
        end
        else
        begin
            rdata_out <= 16'h0000;
        end
    end
end

// ----------------------------------------------------------------
// Receiver
// ----------------------------------------------------------------
always @(posedge core_clk_in)
begin
    if (!rst_n_in)
    begin
        state <= ST_IDLE;
        div_cnt <= 8'h00;
        bit_cnt <= 4'h0;
        shift <= 9'h000;
        rx_data <= 9'h000;
        rx_prev <= 1'b1;
        par_acc <= 1'b0;
        stop_cnt <= 1'b0;
        rx_active <= 1'b0;
        rx_done <= 1'b0;
        parity_error <= 1'b0;
        framing_error <= 1'b0;
        enable_wait <= 3'h0;
        armed <= 1'b0;
    end
    else if (clk_en_in)
    begin
        rx_prev <= rx_line;
        // Done, parity error and framing error flags clear on a read of the status register
        if (rd_in && (addr_in == `OFS_RX_STATUS))
        begin
            rx_done <= 1'b0;
            parity_error <= 1'b0;
            framing_error <= 1'b0;
        end
        // Four-cycle settle window after enable; start is ignored until it ends
        if (!receive_enable_bit)
        begin
            enable_wait <= `RX_ENABLE_WAIT_CYCLES;
            armed <= 1'b0;
        end
        else if (enable_wait != 3'h0)
        begin
            enable_wait <= enable_wait - 3'h1;
        end
        else if (channel_start_trigger)
        begin
            armed <= 1'b1;
        end
        if (!tick)
        begin
            div_cnt <= div_cnt - 8'h01;
        end
        case (state)
            ST_IDLE:
            begin
                if (armed && rx_prev && !rx_line)
                begin
                    state <= ST_START;
                    div_cnt <= half_period - 8'h01;
                    rx_active <= 1'b1;
                end
            end
            ST_START:
            begin
                if (tick)
                begin
                    div_cnt <= half_period + half_period - 8'h01;
                    if (rx_line)
                    begin
                        state <= ST_IDLE;
                        rx_active <= 1'b0;
                    end
                    else
                    begin
                        state <= ST_DATA;
                        bit_cnt <= 4'h0;
                        par_acc <= 1'b0;
                        shift <= 9'h000;
                    end
                end
            end
            ST_DATA:
            begin
                if (tick)
                begin
                    div_cnt <= half_period + half_period - 8'h01;
                    par_acc <= par_acc ^ rx_line;
                    if (bit_order_select)
                    begin
                        shift <= {rx_line, shift[8:1]};
                    end
                    else
                    begin
                        shift <= {shift[7:0], rx_line};
                    end
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt + 4'h1 == data_bits(char_length_sel))
                    begin
                        stop_cnt <= 1'b0;
                        if (parity_sel == `PTC_NONE)
                        begin
                            state <= ST_STOP;
                        end
                        else
                        begin
                            state <= ST_PARITY;
                        end
                    end
                end
            end
            ST_PARITY:
            begin
                if (tick)
                begin
                    div_cnt <= half_period + half_period - 8'h01;
                    state <= ST_STOP;
                    if (((parity_sel == `PTC_EVEN) && (par_acc ^ rx_line)) ||
                        ((parity_sel == `PTC_ODD) && !(par_acc ^ rx_line)))
                    begin
                        parity_error <= 1'b1;
                    end
                end
            end
            ST_STOP:
            begin
                if (tick || (stop_bit_sel == `SLC_NONE))
                begin
                    div_cnt <= half_period + half_period - 8'h01;
                    if ((stop_bit_sel != `SLC_NONE) && !rx_line)
                    begin
                        framing_error <= 1'b1;
                    end
                    if ((stop_bit_sel == `SLC_TWO) && !stop_cnt)
                    begin
                        stop_cnt <= 1'b1;
                    end
                    else
                    begin
                        state <= ST_IDLE;
                        rx_active <= 1'b0;
                        rx_done <= 1'b1;
                        // Right-align shorter characters taken LSB first
                        if (bit_order_select)
                        begin
                            rx_data <= shift >> (4'h9 - data_bits(char_length_sel));
                        end
                        else
                        begin
                            rx_data <= shift;
                        end
                    end
                end
            end
            default:
            begin
                state <= ST_IDLE;
                rx_active <= 1'b0;
            end
        endcase
    end
end

endmodule

// ### tb/uart_channel_setup_asserts.sv
// Checker on the ports of the serial channel setup block
// Assumes bind to the design top and the shared defines header
`timescale 1ns/1ps
`include "uart_channel_setup_defines.vh"
module uart_channel_setup_chk
(
    input wire core_clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [15:0] rdata_out,
    input wire [7:0] port_a_pin_out,
    input wire [7:0] port_a_pin_oe_n_out,
    input wire [7:0] port_b_pin_out,
    input wire [7:0] port_b_pin_oe_n_out
);
    // ----------------------------------------------------------------
    // Shadow of the transmit pin controls
    // ----------------------------------------------------------------
    reg lat;
    reg lvl;
    reg gate;
    wire wr_ok = clk_en_in && wr_in;
    wire rd_ok = clk_en_in && rd_in;
    wire [7:0] wlow = wdata_in[7:0];
    wire tx_exp = lat & (gate ? lvl : 1'b1);
    always @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            lat <= 1'b1;
            lvl <= 1'b1;
            gate <= 1'b1;
        end
        else if (wr_ok)
        begin
            if (addr_in == `OFS_PORT_A_LATCH)
                lat <= wdata_in[0];
            if (addr_in == `OFS_SERIAL_OUTPUT_LEVEL)
                lvl <= wdata_in[0];
            if (addr_in == `OFS_SERIAL_OUTPUT_ENABLE)
                gate <= wdata_in[0];
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_TX_LEVEL: assert property (clk_en_in |=> port_a_pin_out[0] == $past(tx_exp))
        else $error("transmit pin level wrong");
    AST_A_DIR_WRITE: assert property ((wr_ok && addr_in == `OFS_PORT_A_DIRECTION) ##1 clk_en_in
        |=> port_a_pin_oe_n_out == $past(wlow, 2))
        else $error("port a enable not taken from write");
    AST_A_LATCH_UPPER: assert property ((wr_ok && addr_in == `OFS_PORT_A_LATCH) ##1 clk_en_in
        |=> port_a_pin_out[7:1] == $past(wlow[7:1], 2))
        else $error("port a drive not taken from write");
    AST_B_LATCH_WRITE: assert property ((wr_ok && addr_in == `OFS_PORT_B_LATCH) ##1 clk_en_in
        |=> port_b_pin_out == $past(wlow, 2))
        else $error("port b drive not taken from write");
    AST_B_DIR_WRITE: assert property ((wr_ok && addr_in == `OFS_PORT_B_DIRECTION) ##1 clk_en_in
        |=> port_b_pin_oe_n_out == $past(wlow, 2))
        else $error("port b enable not taken from write");
    AST_A_DIR_READ: assert property (rd_ok && addr_in == `OFS_PORT_A_DIRECTION
        |=> rdata_out == {8'h00, port_a_pin_oe_n_out})
        else $error("port a direction readback wrong");
    AST_DIV_READ: assert property (wr_ok && addr_in == `OFS_RX_CHANNEL_DIVIDER_DATA
        ##1 !wr_in ##1 (rd_ok && addr_in == `OFS_RX_CHANNEL_DIVIDER_DATA)
        |=> rdata_out == $past(wdata_in, 3))
        else $error("divider readback wrong");
    AST_FREEZE: assert property (!clk_en_in
        |=> $stable(port_b_pin_out) && $stable(port_a_pin_out))
        else $error("pins moved while clock enable low");
    cover property (wr_ok && addr_in == `OFS_RX_START);
    cover property (rd_ok && addr_in == `OFS_RX_STATUS);
    cover property (port_a_pin_out[0] == 1'b0);
endmodule
bind uart_channel_setup uart_channel_setup_chk u_chk (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .port_a_pin_out(port_a_pin_out),
    .port_a_pin_oe_n_out(port_a_pin_oe_n_out), .port_b_pin_out(port_b_pin_out),
    .port_b_pin_oe_n_out(port_b_pin_oe_n_out));

// ### tb/uart_remote.sv
// Remote serial device driving the idle-high receive line
// Assumes send is called just after a rising clock edge
`timescale 1ns/1ps
module uart_remote
(
    input wire clk_in,
    output reg line_out
);
    integer i;
    initial line_out = 1'b1;
    task bit_out(input b, input integer bt);
    begin
        line_out <= b;
        repeat (bt) @(posedge clk_in);
    end
    endtask
    // ----------------------------------------------------------------
    // One character: start, data, optional parity, stop, idle
    // ----------------------------------------------------------------
    task send(input [8:0] d, input integer n, input [1:0] ptc, input msb,
        input bad_par, input bad_stop, input integer bt);
        reg par;
    begin
        par = ^d ^ (ptc == 2'h3) ^ bad_par;
        bit_out(1'b0, bt);
        for (i = 0; i < n; i = i + 1)
            bit_out(msb ? d[n - 1 - i] : d[i], bt);
        if (ptc != 2'h0)
            bit_out((ptc == 2'h1) ? bad_par : par, bt);
        bit_out(~bad_stop, bt);
        bit_out(1'b1, bt);
    end
    endtask
endmodule

// ### tb/test_uart_channel_setup.sv
// Self-checking bench for the serial channel setup block
// Assumes the remote device model and the checker bound to the design
`timescale 1ns/1ps
`include "uart_channel_setup_defines.vh"
module test_uart_channel_setup;
    reg core_clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg clk_en_in = 1'b1;
    reg [3:0] addr_in = 4'h0;
    reg [15:0] wdata_in = 16'h0000;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg [7:0] port_a_pin_in = 8'h00;
    reg [6:0] pin_b_low = 7'h00;
    wire rx_line;
    wire [15:0] rdata_out;
    wire [7:0] pa_out;
    wire [7:0] pa_oe_n;
    wire [7:0] pb_out;
    wire [7:0] pb_oe_n;
    integer seed = 66070;
    integer fail_count = 0;
    integer total_checks = 0;
    integer bt = 156;
    integer k;
    reg [4:0] j;
    reg [15:0] v;
    reg [15:0] x;
    reg [1:0] slc = `SLC_ONE;
    always #2 core_clk_in = ~core_clk_in;
    uart_channel_setup u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .port_a_pin_in(port_a_pin_in), .port_b_pin_in({rx_line, pin_b_low}),
        .rdata_out(rdata_out), .port_a_pin_out(pa_out), .port_a_pin_oe_n_out(pa_oe_n),
        .port_b_pin_out(pb_out), .port_b_pin_oe_n_out(pb_oe_n));
    uart_remote u_remote (.clk_in(core_clk_in), .line_out(rx_line));
    // ----------------------------------------------------------------
    // Bus tasks, comparison and expectations
    // ----------------------------------------------------------------
    task check(input [15:0] seen, input [15:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task conclude;
    begin
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task wr(input [3:0] a, input [15:0] d);
    begin
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    end
    endtask
    task rd(input [3:0] a, output [15:0] d);
    begin
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    end
    endtask
    function [15:0] cfg(input rxe, input [1:0] ptc, input dir, input [1:0] dls);
        cfg = {1'b0, rxe, 3'h0, 1'b1, ptc, dir, 1'b0, slc, 1'b0, 1'b1, dls};
    endfunction
    function tx_pin(input l, input s, input g);
        tx_pin = l & (g ? s : 1'b1);
    endfunction
    task rx_case(input [1:0] ptc, input dir, input [1:0] dls, input bp, input bs);
        integer n;
        reg [8:0] d;
    begin
        n = (dls == `DLS_9BIT) ? 9 : ((dls == `DLS_7BIT) ? 7 : 8);
        d = $random(seed);
        d = d & ((9'h001 << n) - 9'h001);
        wr(`OFS_RX_CHANNEL_COMM_CONFIG, cfg(1'b1, ptc, dir, dls));
        u_remote.send(d, n, ptc, ~dir, bp, bs, bt);
        x = 16'h0000;
        for (k = 0; k < 20 && x[0] !== 1'b1; k = k + 1)
            rd(`OFS_RX_STATUS, x);
        if (x[0] !== 1'b1)
        begin
            fail_count = fail_count + 1;
            conclude;
        end
        check(x[3:0], {1'b0, bs, bp & ptc[1], 1'b1});
        rd(`OFS_RX_DATA, x);
        if (!bp && !bs)
            check(x, {7'h00, d});
    end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        rd(`OFS_RX_CHANNEL_COMM_CONFIG, x);
        check(x, `RST_COMM_CONFIG);
        rd(`OFS_RX_CHANNEL_DIVIDER_DATA, x);
        check(x, `RST_DIVIDER_DATA);
        rd(`OFS_SERIAL_OUTPUT_LEVEL, x);
        check(x, `RST_OUTPUT_LEVEL);
        rd(`OFS_SERIAL_OUTPUT_ENABLE, x);
        check(x, `RST_OUTPUT_ENABLE);
        rd(`OFS_PORT_A_LATCH, x);
        check(x, `RST_PORT_A_LATCH);
        rd(`OFS_PORT_A_DIRECTION, x);
        check(x, `RST_PORT_A_DIRECTION);
        rd(`OFS_PORT_B_LATCH, x);
        check(x, `RST_PORT_B_LATCH);
        rd(`OFS_PORT_B_DIRECTION, x);
        check(x, `RST_PORT_B_DIRECTION);
        check({pa_out, pa_oe_n}, 16'h01FE);
        rd(4'hF, x);
        check(x, 16'h0000);
        for (k = 0; k < 24; k = k + 1)
        begin
            v = $random(seed);
            j = 5'h05 + k % 3;
            wr(j[3:0], v);
            port_a_pin_in <= v[15:8];
            pin_b_low <= v[14:8];
            rd(j[3:0], x);
            check(x, {8'h00, v[7:0]});
            x = (j == 5'h05) ? pa_oe_n : ((j == 5'h06) ? pb_out : pb_oe_n);
            check(x, {8'h00, v[7:0]});
        end
        for (j = 0; j < 8; j = j + 1)
        begin
            v = $random(seed);
            wr(`OFS_PORT_A_LATCH, {8'h00, v[7:1], j[0]});
            wr(`OFS_SERIAL_OUTPUT_LEVEL, {15'h0787, j[1]});
            wr(`OFS_SERIAL_OUTPUT_ENABLE, {15'h0000, j[2]});
            @(posedge core_clk_in);
            #1 check(pa_out, {v[7:1], tx_pin(j[0], j[1], j[2])});
        end
        wr(`OFS_PORT_B_LATCH, 16'h003C);
        clk_en_in <= 1'b0;
        wr(`OFS_PORT_B_LATCH, 16'h00A5);
        clk_en_in <= 1'b1;
        rd(`OFS_PORT_B_LATCH, x);
        check(x, 16'h003C);
        wr(`OFS_RX_START, 16'h0001);
        rx_case(`PTC_EVEN, 1'b1, `DLS_8BIT, 1'b0, 1'b0);
        wr(`OFS_RX_CHANNEL_DIVIDER_DATA, 16'h0600);
        rd(`OFS_RX_CHANNEL_DIVIDER_DATA, x);
        check(x, 16'h0600);
        bt = 8;
        for (j = 0; j < 12; j = j + 1)
        begin
            v = $random(seed);
            rx_case(j[1:0], v[0], j[3:2] + 2'h1, 1'b0, 1'b0);
        end
        rx_case(`PTC_EVEN, 1'b1, `DLS_8BIT, 1'b1, 1'b0);
        rx_case(`PTC_ODD, 1'b0, `DLS_7BIT, 1'b1, 1'b0);
        rx_case(`PTC_ZERO, 1'b1, `DLS_9BIT, 1'b1, 1'b0);
        rx_case(`PTC_NONE, 1'b1, `DLS_8BIT, 1'b0, 1'b1);
        slc = `SLC_TWO;
        rx_case(`PTC_ODD, 1'b1, `DLS_9BIT, 1'b0, 1'b0);
        slc = `SLC_NONE;
        rx_case(`PTC_EVEN, 1'b0, `DLS_8BIT, 1'b0, 1'b0);
        slc = `SLC_ONE;
        wr(`OFS_RX_CHANNEL_COMM_CONFIG, cfg(1'b0, `PTC_EVEN, 1'b1, `DLS_8BIT));
        wr(`OFS_RX_CHANNEL_COMM_CONFIG, cfg(1'b1, `PTC_EVEN, 1'b1, `DLS_8BIT));
        wr(`OFS_RX_START, 16'h0001);
        u_remote.send(9'h05A, 8, `PTC_EVEN, 1'b0, 1'b0, 1'b0, bt);
        rd(`OFS_RX_STATUS, x);
        check({x[4], x[0]}, 2'h2);
        wr(`OFS_RX_START, 16'h0001);
        rx_case(`PTC_EVEN, 1'b1, `DLS_8BIT, 1'b0, 1'b0);
        conclude;
    end
endmodule
